// ==== design/mfunc_route_pkg.sv ====
// Purpose: Shared constants and routing lookup for the terminal router
// Assumes: Selector codes are 4 bits, seven terminals, 28 routing bits
// Notes:   Source index table shared by the top and each terminal driver
package mfunc_route_pkg;

   localparam int          NUM_TERMS      = 7;
   localparam int          SEL_W          = 4;
   localparam int          ROUTE_W        = 28;
   localparam int          SRC_W          = 29;
   localparam logic [7:0]  ROUTE_OFFSET   = 8'h8c;
   localparam logic [31:0] ROUTE_RESET    = 32'h0000_1000;
   localparam logic [31:0] ROUTE_WMASK    = 32'h0fff_ffff;
   localparam logic [3:0]  CODE_GPI       = 4'h0;
   localparam logic [1:0]  STRAP_WAIT     = 2'h2;

   // Indices into the source vector; 0 to 15 are the interrupt lines
   localparam logic [4:0]  SRC_CLKRUN     = 5'h10;
   localparam logic [4:0]  SRC_SERIRQ     = 5'h11;
   localparam logic [4:0]  SRC_GRANT      = 5'h12;
   localparam logic [4:0]  SRC_REQUEST    = 5'h13;
   localparam logic [4:0]  SRC_LOCK       = 5'h14;
   localparam logic [4:0]  SRC_LOWPWR     = 5'h15;
   localparam logic [4:0]  SRC_LED        = 5'h16;
   localparam logic [4:0]  SRC_EVENT      = 5'h17;
   localparam logic [4:0]  SRC_RING       = 5'h18;
   localparam logic [4:0]  SRC_VIDEO_PORT_STATUS     = 5'h19;
   localparam logic [4:0]  SRC_ZVSEL      = 5'h1a;
   localparam logic [4:0]  SRC_AUDIO      = 5'h1b;
   localparam logic [4:0]  SRC_GPO        = 5'h1c;

   // Returns {defined, source index} for a terminal and selector code
   function automatic logic [5:0] route_lookup(input logic [2:0] term,
                                               input logic [3:0] code);
      logic [5:0] r;
      r = 6'h00;
      case (term)
         3'h6: begin
            if (code == 4'h1) r = {1'b1, SRC_CLKRUN};
            else if (code != 4'h0) r = {1'b1, 1'b0, code};
         end
         3'h5: begin
            case (code)
               4'h1: r = {1'b1, SRC_GPO};
               4'h2: r = {1'b1, SRC_GRANT};
               4'h4, 4'ha, 4'hb, 4'hf: r = {1'b1, 1'b0, code};
               4'h8: r = {1'b1, SRC_AUDIO};
               4'h9: r = {1'b1, SRC_LOWPWR};
               4'hc, 4'hd: r = {1'b1, SRC_LED};
               4'he: r = {1'b1, SRC_EVENT};
               default: r = 6'h00;
            endcase
         end
         3'h4: begin
            case (code)
               4'h1: r = {1'b1, SRC_GPO};
               4'h2: r = {1'b1, SRC_LOCK};
               4'hc: r = {1'b1, SRC_RING};
               4'hd: r = {1'b1, SRC_LED};
               4'he: r = {1'b1, SRC_EVENT};
               4'hf: r = {1'b1, SRC_LOWPWR};
               default: r = 6'h00;
            endcase
         end
         3'h3: begin
            if (code == 4'h1) r = {1'b1, SRC_SERIRQ};
            else if (code != 4'h0) r = {1'b1, 1'b0, code};
         end
         3'h2: begin
            case (code)
               4'h1: r = {1'b1, SRC_GPO};
               4'h2: r = {1'b1, SRC_REQUEST};
               4'h4, 4'h5, 4'h9, 4'ha, 4'hb: r = {1'b1, 1'b0, code};
               4'h6: r = {1'b1, SRC_VIDEO_PORT_STATUS};
               4'h7: r = {1'b1, SRC_ZVSEL};
               4'h8: r = {1'b1, SRC_AUDIO};
               4'hc: r = {1'b1, SRC_RING};
               4'hd: r = {1'b1, SRC_LOWPWR};
               4'he: r = {1'b1, SRC_EVENT};
               4'hf: r = {1'b1, 5'h07};
               default: r = 6'h00;
            endcase
         end
         3'h1: begin
            case (code)
               4'h1: r = {1'b1, SRC_GPO};
               4'h2: r = {1'b1, SRC_LOWPWR};
               4'h3, 4'h4, 4'h5, 4'h9, 4'ha, 4'hb, 4'hd: r = {1'b1, 1'b0, code};
               4'h6: r = {1'b1, SRC_VIDEO_PORT_STATUS};
               4'h7: r = {1'b1, SRC_ZVSEL};
               4'h8: r = {1'b1, SRC_AUDIO};
               default: r = 6'h00;
            endcase
         end
         3'h0: begin
            case (code)
               4'h1: r = {1'b1, SRC_GPO};
               4'h3, 4'h4, 4'ha, 4'hb, 4'hd: r = {1'b1, 1'b0, code};
               4'h7: r = {1'b1, SRC_ZVSEL};
               4'hc: r = {1'b1, SRC_LED};
               default: r = 6'h00;
            endcase
         end
         default: r = 6'h00;
      endcase
      return r;
   endfunction

endpackage

// ==== design/terminal_driver.sv ====
// Purpose: Selects the function driven onto one multifunction terminal
// Assumes: Source vector built by the router top, same clock
// Notes:   Purely combinational; the top registers the result
`timescale 1ns/1ps
module terminal_driver
   import mfunc_route_pkg::*;
#(
   parameter logic [2:0] TERM = 3'h0
) (
   input  wire logic [SEL_W-1:0] sel,
   input  wire logic [SRC_W-1:0] src,
   output logic                  drive,
   output logic                  enable
);

   logic [5:0] hit;

   always_comb begin
      hit    = route_lookup(TERM, sel);
      enable = hit[5];
      drive  = hit[5] ? src[hit[4:0]] : 1'b0;
   end

endmodule // terminal_driver

// ==== design/multifunction_terminal_router.sv ====
// Purpose: APB routing register steering seven multifunction terminals
// Assumes: Functions and EEPROM loader run on core_clk; pins are asynchronous
// Notes:   Zero wait state slave with registered answer one cycle after setup
//
// Operation
// - One 32-bit routing register, default 0000_1000h
// - Bits 31 to 28 read zero, ignore writes
// - Zero selector means general-purpose input on terminals 0, 1, 2, 4 and 5; in serial mode gp_input_1 and gp_input_3 stay 0
// - Initial value loadable from serial EEPROM
// - Terminal 6: clock-run or interrupt lines
// - Terminal 5 function map
// - Terminal 4 function map
// - Terminal 3: serial interrupt or interrupt lines
// - Terminal 2 function map
// - Terminal 1 function map
// - Serial mode: terminal 1 carries SDA
// - Terminal 0 function map
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module multifunction_terminal_router
   import mfunc_route_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input  wire logic              core_clk,
   input  wire logic              reset_n,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr,
   input  wire logic              eeprom_load_valid,
   input  wire logic [ROUTE_W-1:0] eeprom_load_data,
   input  wire logic              sda_drive_low,
   input  wire logic              scl_drive_low,
   output logic                   sda_sense,
   output logic                   serial_mode,
   input  wire logic              supply_control_0,
   input  wire logic              supply_control_1,
   input  wire logic              gp_output_0,
   input  wire logic              gp_output_1,
   input  wire logic              gp_output_2,
   input  wire logic              gp_output_3,
   input  wire logic              gp_output_4,
   output logic                   gp_input_0,
   output logic                   gp_input_1,
   output logic                   gp_input_2,
   output logic                   gp_input_3,
   output logic                   gp_input_4,
   input  wire logic [15:0]       irq_request,
   input  wire logic              clock_run,
   input  wire logic              serial_interrupt,
   input  wire logic              pci_grant_out,
   input  wire logic              pci_request_out,
   input  wire logic              pci_lock,
   input  wire logic              low_power_state_flag,
   input  wire logic              socket_activity_led,
   input  wire logic              general_purpose_event,
   input  wire logic              ring_indicate_output,
   input  wire logic              video_port_status,
   input  wire logic              video_port_select,
   input  wire logic              card_audio_pwm,
   input  wire logic              multi_pin_0_in,
   input  wire logic              multi_pin_1_in,
   input  wire logic              multi_pin_2_in,
   input  wire logic              multi_pin_3_in,
   input  wire logic              multi_pin_4_in,
   input  wire logic              multi_pin_5_in,
   input  wire logic              multi_pin_6_in,
   output logic                   multi_pin_0_out,
   output logic                   multi_pin_1_out,
   output logic                   multi_pin_2_out,
   output logic                   multi_pin_3_out,
   output logic                   multi_pin_4_out,
   output logic                   multi_pin_5_out,
   output logic                   multi_pin_6_out,
   output logic                   multi_pin_0_oe,
   output logic                   multi_pin_1_oe,
   output logic                   multi_pin_2_oe,
   output logic                   multi_pin_3_oe,
   output logic                   multi_pin_4_oe,
   output logic                   multi_pin_5_oe,
   output logic                   multi_pin_6_oe
);

   logic [ROUTE_W-1:0]   route_q, route_d;
   logic                 pready_q, pready_d;
   logic                 pslverr_q, pslverr_d;
   logic [31:0]          prdata_q, prdata_d;
   logic [8:0]           meta_q, sync_q;
   logic [8:0]           pin_raw;
   logic [1:0]           strap_cnt_q, strap_cnt_d;
   logic                 serial_q, serial_d;
   logic                 boot_q, boot_d;
   logic [NUM_TERMS-1:0] out_q, out_d, oe_q, oe_d;
   logic [NUM_TERMS-1:0] fn_drive, fn_enable;
   logic [4:0]           gpi_q, gpi_d;
   logic [4:0]           gpo;
   logic                 addr_hit;
   logic                 wr_take;
   logic [31:0]          wr_merge;
   logic [SRC_W-1:0]     src_base;
   logic                 sense_q, sense_d;

   assign addr_hit = (paddr[ADDR_W-1:2] == ROUTE_OFFSET[ADDR_W-1:2]);
   assign wr_take  = psel & penable & pready_q & pwrite & addr_hit;
   assign gpo      = {gp_output_4, gp_output_3, gp_output_2, gp_output_1, gp_output_0};
   assign pin_raw  = {supply_control_1, supply_control_0, multi_pin_6_in, multi_pin_5_in,
                      multi_pin_4_in, multi_pin_3_in, multi_pin_2_in, multi_pin_1_in,
                      multi_pin_0_in};
   assign src_base = {1'b0, card_audio_pwm, video_port_select, video_port_status,
                      ring_indicate_output, general_purpose_event, socket_activity_led,
                      low_power_state_flag, pci_lock, pci_request_out, pci_grant_out,
                      serial_interrupt, clock_run, irq_request};

   // Register bus and routing register
   always_comb begin
      route_d   = route_q;
      pready_d  = psel & ~penable;
      pslverr_d = psel & ~penable & ~addr_hit;
      prdata_d  = 32'h0000_0000;
      wr_merge  = {4'h0, route_q};
      for (int b = 0; b < 4; b++) begin
         if (pstrb[b]) wr_merge[8*b +: 8] = pwdata[8*b +: 8];
      end
      wr_merge = wr_merge & ROUTE_WMASK;
      if (eeprom_load_valid) route_d = eeprom_load_data;
      else if (wr_take) route_d = wr_merge[ROUTE_W-1:0];
      if (psel & ~penable & addr_hit & ~pwrite) prdata_d = {4'h0, route_q};
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         route_q   <= ROUTE_RESET[ROUTE_W-1:0];
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         route_q   <= route_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q  <= prdata_d;
      end
   end

   // Two-stage pin synchronisers
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_q <= 9'h000;
         sync_q <= 9'h000;
      end else begin
         meta_q <= pin_raw;
         sync_q <= meta_q;
      end
   end

   always_comb begin
      strap_cnt_d = strap_cnt_q;
      serial_d    = serial_q;
      boot_d      = 1'b1;
      // Count past capture so the strap is read once
      if (strap_cnt_q != STRAP_WAIT + 2'h1) strap_cnt_d = strap_cnt_q + 2'h1;
      // Synchroniser holds the strap two edges after release
      if (strap_cnt_q == STRAP_WAIT) serial_d = sync_q[7] & sync_q[8];
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         strap_cnt_q <= 2'h0;
         serial_q    <= 1'b0;
         boot_q      <= 1'b0;
      end else begin
         strap_cnt_q <= strap_cnt_d;
         serial_q    <= serial_d;
         boot_q      <= boot_d;
      end
   end

   // One function selector per terminal
   generate
      for (genvar t = 0; t < NUM_TERMS; t++) begin : g_term
         localparam int GPO_IDX = (t < 3) ? t : ((t == 4) ? 3 : 4);
         terminal_driver #(
            .TERM (3'(t))
         ) u_drv (
            .sel    (route_q[SEL_W*t +: SEL_W]),
            .src    ({(t == 3 || t == 6) ? 1'b0 : gpo[GPO_IDX], src_base[SRC_W-2:0]}),
            .drive  (fn_drive[t]),
            .enable (fn_enable[t])
         );
      end
   endgenerate

   always_comb begin
      out_d = fn_drive;
      oe_d  = fn_enable;
      if (serial_q) begin
         out_d[1] = 1'b0;
         oe_d[1]  = sda_drive_low;
         out_d[4] = 1'b0;
         oe_d[4]  = scl_drive_low;
      end
      gpi_d[0] = (route_q[3:0] == CODE_GPI) & sync_q[0];
      gpi_d[1] = (route_q[7:4] == CODE_GPI) & ~serial_q & sync_q[1];
      gpi_d[2] = (route_q[11:8] == CODE_GPI) & sync_q[2];
      gpi_d[3] = (route_q[19:16] == CODE_GPI) & ~serial_q & sync_q[4];
      gpi_d[4] = (route_q[23:20] == CODE_GPI) & sync_q[5];
      sense_d  = gpi_d[1] | (serial_q & sync_q[1]);
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         out_q <= 7'h00;
         oe_q  <= 7'h00;
         gpi_q <= 5'h00;
         sense_q <= 1'b0;
      end else begin
         out_q <= out_d;
         oe_q  <= oe_d;
         gpi_q <= gpi_d;
         sense_q <= sense_d;
      end
   end

   assign pready          = pready_q;
   assign prdata          = prdata_q;
   assign pslverr         = pslverr_q;
   assign serial_mode     = serial_q;
   assign sda_sense       = sense_q;
   assign gp_input_0      = gpi_q[0];
   assign gp_input_1      = gpi_q[1];
   assign gp_input_2      = gpi_q[2];
   assign gp_input_3      = gpi_q[3];
   assign gp_input_4      = gpi_q[4];
   assign multi_pin_0_out = out_q[0];
   assign multi_pin_1_out = out_q[1];
   assign multi_pin_2_out = out_q[2];
   assign multi_pin_3_out = out_q[3];
   assign multi_pin_4_out = out_q[4];
   assign multi_pin_5_out = out_q[5];
   assign multi_pin_6_out = out_q[6];
   assign multi_pin_0_oe  = oe_q[0];
   assign multi_pin_1_oe  = oe_q[1];
   assign multi_pin_2_oe  = oe_q[2];
   assign multi_pin_3_oe  = oe_q[3];
   assign multi_pin_4_oe  = oe_q[4];
   assign multi_pin_5_oe  = oe_q[5];
   assign multi_pin_6_oe  = oe_q[6];

   reset_value_a: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      !boot_q |-> route_q == ROUTE_RESET[ROUTE_W-1:0])
      else $error("routing register not at default after reset");

   upper_zero_a: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      pready_q |-> prdata_q[31:28] == 4'h0)
      else $error("reserved routing bits read nonzero");

   write_lands_a: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      wr_take && pstrb == 4'hf && !eeprom_load_valid
      |=> route_q == $past(pwdata[ROUTE_W-1:0]))
      else $error("full routing write not stored");

   eeprom_load_a: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      eeprom_load_valid |=> route_q == $past(eeprom_load_data))
      else $error("eeprom value not loaded");

   gpi_float_a: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      route_q[3:0] == CODE_GPI ##1 route_q[3:0] == CODE_GPI |-> !multi_pin_0_oe)
      else $error("terminal 0 driven in input mode");

   clkrun_route_a: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      route_q[27:24] == 4'h1 |=> multi_pin_6_oe && multi_pin_6_out == $past(clock_run))
      else $error("terminal 6 not carrying clock-run");

   irq_route_a: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      route_q[15:12] == 4'h5 |=> multi_pin_3_oe && multi_pin_3_out == $past(irq_request[5]))
      else $error("terminal 3 not carrying interrupt 5");

   undefined_float_a: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      route_q[23:20] == 4'h3 |=> !multi_pin_5_oe)
      else $error("terminal 5 driven for undefined code");

   sda_override_a: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      serial_q && sda_drive_low |=> multi_pin_1_oe && !multi_pin_1_out)
      else $error("terminal 1 not pulling SDA low");

   scl_override_a: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      serial_q && !scl_drive_low |=> !multi_pin_4_oe)
      else $error("terminal 4 driven while SCL released");

endmodule // multifunction_terminal_router

// ==== tb/board_model.sv ====
// Purpose: Board side of the seven multifunction terminals
// Assumes: Each terminal has a board pull level used while the router releases it
// Notes:   Pure wire resolution, no clock of its own
`timescale 1ns/1ps
module board_model (
   input  wire logic [6:0] pin_out,
   input  wire logic [6:0] pin_oe,
   input  wire logic [6:0] pull_level,
   output logic [6:0]      pin_level
);
   // Released pins go to the board pull level
   assign pin_level = (pin_oe & pin_out) | (~pin_oe & pull_level);
endmodule // board_model

// ==== tb/multifunction_terminal_router_test.sv ====
// Purpose: Register, routing map and serial mode tests of the terminal router
// Assumes: APB slave answering with pready, sampled at rising edges
// Notes:   Source n of the bench vector carries bit b of n for pattern b
`timescale 1ns/1ps
module multifunction_terminal_router_test;
   import mfunc_route_pkg::*;
   logic        core_clk, reset_n, psel, penable, pwrite, ld_valid, sda_low, scl_low;
   logic [7:0]  paddr;
   logic [31:0] pwdata, rdata;
   logic [3:0]  pstrb;
   logic [27:0] ld_data;
   logic [1:0]  supply;
   logic [28:0] src_v;
   logic [6:0]  pull_v;
   logic        err;
   wire logic   pready, pslverr, sda_sense, serial_mode;
   wire logic [31:0] prdata;
   wire logic [6:0]  out_v, oe_v, pin_v;
   wire logic [4:0]  gpi_v;
   int          fail_count, n_tests;
   // Source per code, code 15 in the top byte; 1f means undriven
   localparam logic [127:0] tbl [7] = '{128'h1f1f0d16_0b0a1f1f_1a1f1f04_031f1c1f,
      128'h1f1f0d1f_0b0a091b_1a190504_03151c1f, 128'h07171518_0b0a091b_1a190504_1f131c1f,
      128'h0f0e0d0c_0b0a0908_07060504_0302111f, 128'h15171618_1f1f1f1f_1f1f1f1f_1f141c1f,
      128'h0f171616_0b0a151b_1f1f1f04_1f121c1f, 128'h0f0e0d0c_0b0a0908_07060504_0302101f};
   localparam int gp_term [5] = '{0, 1, 2, 4, 5};

   multifunction_terminal_router #(.ADDR_W(8)) uut (
      .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .eeprom_load_valid(ld_valid),
      .eeprom_load_data(ld_data), .sda_drive_low(sda_low), .scl_drive_low(scl_low),
      .sda_sense(sda_sense), .serial_mode(serial_mode), .supply_control_0(supply[0]),
      .supply_control_1(supply[1]), .gp_output_0(src_v[28]), .gp_output_1(src_v[28]),
      .gp_output_2(src_v[28]), .gp_output_3(src_v[28]), .gp_output_4(src_v[28]),
      .gp_input_0(gpi_v[0]), .gp_input_1(gpi_v[1]), .gp_input_2(gpi_v[2]),
      .gp_input_3(gpi_v[3]), .gp_input_4(gpi_v[4]), .irq_request(src_v[15:0]),
      .clock_run(src_v[16]), .serial_interrupt(src_v[17]), .pci_grant_out(src_v[18]),
      .pci_request_out(src_v[19]), .pci_lock(src_v[20]),
      .low_power_state_flag(src_v[21]), .socket_activity_led(src_v[22]),
      .general_purpose_event(src_v[23]), .ring_indicate_output(src_v[24]),
      .video_port_status(src_v[25]), .video_port_select(src_v[26]),
      .card_audio_pwm(src_v[27]), .multi_pin_0_in(pin_v[0]), .multi_pin_1_in(pin_v[1]),
      .multi_pin_2_in(pin_v[2]), .multi_pin_3_in(pin_v[3]), .multi_pin_4_in(pin_v[4]),
      .multi_pin_5_in(pin_v[5]), .multi_pin_6_in(pin_v[6]), .multi_pin_0_out(out_v[0]),
      .multi_pin_1_out(out_v[1]), .multi_pin_2_out(out_v[2]), .multi_pin_3_out(out_v[3]),
      .multi_pin_4_out(out_v[4]), .multi_pin_5_out(out_v[5]), .multi_pin_6_out(out_v[6]),
      .multi_pin_0_oe(oe_v[0]), .multi_pin_1_oe(oe_v[1]), .multi_pin_2_oe(oe_v[2]),
      .multi_pin_3_oe(oe_v[3]), .multi_pin_4_oe(oe_v[4]), .multi_pin_5_oe(oe_v[5]),
      .multi_pin_6_oe(oe_v[6])
   );

   board_model board (
      .pin_out(out_v), .pin_oe(oe_v), .pull_level(pull_v), .pin_level(pin_v)
   );

   always #2.5 core_clk = ~core_clk;

   task automatic final_report;
      $display("Checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      cmp_word({31'h0, got}, {31'h0, exp});
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
   endtask

   // Enables, driven values and input readback for one routing word
   task automatic check_pins(input logic [27:0] r);
      logic [7:0] e;
      logic [3:0] c;
      for (int t = 0; t < 7; t++) begin
         c = r[t*4 +: 4];
         e = tbl[t][c*8 +: 8];
         cmp_bit(oe_v[t], e != 8'h1f); // Enable per code
         if (e != 8'h1f) cmp_bit(out_v[t], src_v[e[4:0]]);
      end
      for (int k = 0; k < 5; k++) begin
         c = r[gp_term[k]*4 +: 4];
         cmp_bit(gpi_v[k], (c == 4'h0) ? pull_v[gp_term[k]] : 1'b0); // Input mode
      end
   endtask

   function automatic logic [28:0] pat(input int b);
      logic [28:0] v;
      for (int i = 0; i < 29; i++) v[i] = i[b];
      return v;
   endfunction

   initial begin
      #20000;
      fail_count++;
      final_report();
   end

   initial begin
      core_clk = 1'b0;
      reset_n = 1'b0;
      {psel, penable, pwrite, ld_valid, sda_low, scl_low} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'h0;
      ld_data = 28'h0;
      supply = 2'h0;
      src_v = pat(0);
      pull_v = 7'h35;
      repeat (3) @(posedge core_clk);
      reset_n <= 1'b1;
      settle(5);
      check_pins(28'h0001000); // Reset routing
      apb(1'b0, 8'h8c, 32'h0, 4'h0);
      cmp_word(rdata, 32'h0000_1000); // Reset value
      apb(1'b1, 8'h8c, 32'hffff_ffff, 4'hf); // Initial programming
      apb(1'b0, 8'h8c, 32'h0, 4'h0);
      cmp_word(rdata, 32'h0fff_ffff); // Top nibble zero
      apb(1'b1, 8'h8c, 32'h0, 4'h1);
      apb(1'b1, 8'h90, 32'h0, 4'hf);
      cmp_bit(err, 1'b1); // Unmapped write refused
      apb(1'b0, 8'h8c, 32'h0, 4'h0);
      cmp_word(rdata, 32'h0fff_ff00); // Byte lane write
      apb(1'b0, 8'h90, 32'h0, 4'h0);
      cmp_word({err, rdata[30:0]}, 32'h8000_0000); // Unmapped read
      @(posedge core_clk);
      ld_valid <= 1'b1;
      ld_data <= 28'h1234567;
      @(posedge core_clk);
      ld_valid <= 1'b0;
      apb(1'b0, 8'h8c, 32'h0, 4'h0);
      cmp_word(rdata, 32'h0123_4567); // Loaded default
      settle(2);
      check_pins(28'h1234567); // Mixed selectors
      for (int c = 0; c < 16; c++) begin
         apb(1'b1, 8'h8c, {4'h0, {7{c[3:0]}}}, 4'hf);
         apb(1'b0, 8'h8c, 32'h0, 4'h0);
         cmp_word(rdata, {4'h0, {7{c[3:0]}}}); // Read back
         for (int b = 0; b < 5; b++) begin
            @(posedge core_clk);
            src_v <= pat(b);
            settle(2);
            check_pins({7{c[3:0]}}); // Every code
         end
      end
      @(posedge core_clk);
      reset_n <= 1'b0;
      supply <= 2'h3;
      pull_v <= 7'h7f;
      repeat (3) @(posedge core_clk);
      reset_n <= 1'b1;
      settle(6);
      cmp_bit(serial_mode, 1'b1); // Strap seen
      for (int d = 0; d < 2; d++) begin
         @(posedge core_clk);
         sda_low <= d[0];
         scl_low <= ~d[0];
         settle(6);
         cmp_bit(oe_v[1], d[0]); // Data line drive
         cmp_bit(oe_v[4], ~d[0]); // Clock line drive
         cmp_word({out_v[1], out_v[4], gpi_v[1], gpi_v[3]}, 32'h0); // Low only
         cmp_bit(sda_sense, ~d[0]); // Data line level
      end
      final_report();
   end
endmodule // multifunction_terminal_router_test
